// >>> core/ptr_seq.v
`include "ptr_defs.vh"
`default_nettype none
// How it works
// - recompute codes every 500 ms when enabled
// - measure only on reference resistor pin
// - apply later codes only during self-refresh; the first goes in at configuration
// - update buffers right after self-refresh entry
// - stay in self-refresh until update and traffic
// - calibration schedule continues in self-refresh only while waiting for traffic
// - exit self-refresh with zq short calibration
// - release traffic after dll relock wait
// - disabled means one calibration at configuration
// - active only when all qualifiers hold
// - entry flushes, precharges, issues self-refresh
// - load new code words, 50-100 ns
// - wait unbounded for user read or write
module ptr_seq #(
	parameter INTERVAL_CYC = `PTR_INTERVAL_CYC,
	parameter RELOCK_CYC = `PTR_RELOCK_CYC,
	parameter CW = `PTR_CODE_W
) (
	// clock and reset
	input wire clock_i,
	input wire rst_i,
	// configuration straps
	input wire enable_i,
	input wire qualified_i,
	// reference resistor calibration engine
	output reg cal_start_o,
	input wire cal_done_i,
	input wire [CW-1:0] cal_code_i,
	// controller handshake
	output reg sr_enter_o,
	input wire sr_entered_i,
	input wire clocks_stopped_i,
	output reg sr_exit_o,
	output reg zqcs_o,
	// user traffic
	input wire user_req_i,
	output reg user_ready_o,
	// buffer termination
	output reg [CW-1:0] buf_code_o,
	output reg busy_o
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [3:0] S_CFG = 4'h0; // configuration calibration
	localparam [3:0] S_RUN = 4'h1; // traffic running
	localparam [3:0] S_ENTER = 4'h2; // entering self-refresh
	localparam [3:0] S_LOAD = 4'h3; // loading code words
	localparam [3:0] S_ARM = 4'h4; // arming automatic exit
	localparam [3:0] S_WAIT = 4'h5; // waiting for user traffic
	localparam [3:0] S_RELOCK = 4'h6; // dll relock
	localparam [3:0] S_IDLE = 4'h7; // single-shot mode done
	localparam [31:0] LOAD_CYC = `PTR_LOAD_CYC;
	localparam [31:0] ARM_CYC = `PTR_ARM_CYC;
	reg [3:0] st_q; // sequencer state
	reg [CW-1:0] new_code_q; // measured, not yet applied
	reg pend_q; // new code awaiting apply
	reg cal_busy_q; // measurement running
	reg [31:0] iv_q; // interval counter
	reg cfg_done_q; // first calibration seen
	reg en_q; // enable and qualifiers latched
	reg t_load; // step timer load
	reg [31:0] t_val; // step timer value
	wire t_done; // step timer expired
	reg [31:0] st_cnt_q; // small step counter
	// step timer for relock wait
	ptr_timer #(.W(32)) u_tmr (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.load_i(t_load),
		.value_i(t_val),
		.done_o(t_done)
	);
	// ----------------------------------------
	// qualifier latch
	// ----------------------------------------
	// straps sampled by a clocked process, never in reset branch
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
		end else begin
			en_q <= enable_i & qualified_i;
		end
	end
	// ----------------------------------------
	// measurement and interval
	// ----------------------------------------
	// calibration runs beside the buffer update path, its interval gated by that path's state
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cal_start_o <= 1'b0;
			cal_busy_q <= 1'b0;
			iv_q <= 32'h0000_0000;
			new_code_q <= `PTR_CODE_RST;
			pend_q <= 1'b0;
			cfg_done_q <= 1'b0;
		end else begin
			cal_start_o <= 1'b0;
			// consumed by the load step; a result landing in the same cycle wins
			if (st_q == S_LOAD && st_cnt_q == 32'h0000_0000)
				pend_q <= 1'b0;
			if (!cfg_done_q && !cal_busy_q) begin
				cal_start_o <= 1'b1;
				cal_busy_q <= 1'b1;
			end else if (cal_busy_q) begin
				if (cal_done_i) begin
					// only the resistor pin, traffic untouched
					cal_busy_q <= 1'b0;
					new_code_q <= cal_code_i;
					cfg_done_q <= 1'b1;
					// configuration code goes straight in, later ones queue
					pend_q <= cfg_done_q;
					iv_q <= 32'h0000_0000;
				end
			end else if (en_q && !pend_q && (st_q == S_RUN || st_q == S_WAIT)) begin
				// no new cycle while update outstanding
				if (iv_q >= INTERVAL_CYC - 1) begin
					cal_start_o <= 1'b1;
					cal_busy_q <= 1'b1;
				end else begin
					iv_q <= iv_q + 32'h0000_0001;
				end
			end
		end
	end
	// ----------------------------------------
	// update sequencer
	// ----------------------------------------
	always @* begin
		t_load = 1'b0;
		t_val = RELOCK_CYC;
		if (st_q == S_WAIT && user_req_i)
			t_load = 1'b1;
	end
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= S_CFG;
			st_cnt_q <= 32'h0000_0000;
			sr_enter_o <= 1'b0;
			sr_exit_o <= 1'b0;
			zqcs_o <= 1'b0;
			user_ready_o <= 1'b0;
			buf_code_o <= `PTR_CODE_RST;
			busy_o <= 1'b1;
		end else begin
			sr_exit_o <= 1'b0;
			zqcs_o <= 1'b0;
			case (st_q)
			S_CFG: begin
				// initial code applied one cycle before traffic is let in
				if (cfg_done_q) begin
					if (st_cnt_q == 32'h0000_0000) begin
						// buffers settle first, traffic still gated
						buf_code_o <= new_code_q;
						st_cnt_q <= 32'h0000_0001;
					end else begin
						st_cnt_q <= 32'h0000_0000;
						user_ready_o <= 1'b1;
						busy_o <= 1'b0;
						st_q <= en_q ? S_RUN : S_IDLE;
					end
				end
			end
			S_RUN: begin
				if (!en_q) begin
					st_q <= S_IDLE;
				end else if (pend_q) begin
					sr_enter_o <= 1'b1;
					user_ready_o <= 1'b0;
					busy_o <= 1'b1;
					st_q <= S_ENTER;
				end
			end
			S_ENTER: begin
				// update as soon as entry confirmed
				if (sr_entered_i && clocks_stopped_i) begin
					st_cnt_q <= 32'h0000_0000;
					st_q <= S_LOAD;
				end
			end
			S_LOAD: begin
				// code load takes the longest figure
				buf_code_o <= new_code_q;
				if (st_cnt_q >= LOAD_CYC - 1) begin
					st_cnt_q <= 32'h0000_0000;
					st_q <= S_ARM;
				end else begin
					st_cnt_q <= st_cnt_q + 32'h0000_0001;
				end
			end
			S_ARM: begin
				// automatic exit armed after this step
				if (st_cnt_q >= ARM_CYC - 1) begin
					st_cnt_q <= 32'h0000_0000;
					busy_o <= 1'b0;
					st_q <= S_WAIT;
				end else begin
					st_cnt_q <= st_cnt_q + 32'h0000_0001;
				end
			end
			S_WAIT: begin
				// held until update done and traffic
				if (user_req_i) begin
					sr_exit_o <= 1'b1;
					zqcs_o <= 1'b1;
					sr_enter_o <= 1'b0;
					busy_o <= 1'b1;
					st_q <= S_RELOCK;
				end
			end
			S_RELOCK: begin
				if (t_done) begin
					user_ready_o <= 1'b1;
					busy_o <= 1'b0;
					st_q <= S_RUN;
				end
			end
			S_IDLE: begin
				// single-shot mode, no later updates
				user_ready_o <= 1'b1;
				busy_o <= 1'b0;
			end
			default: begin
				st_q <= S_CFG;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> core/ptr_defs.vh
`ifndef PTR_DEFS_VH
`define PTR_DEFS_VH
// ----------------------------------------
// timing
// ----------------------------------------
// recalibration interval in ms
`define PTR_INTERVAL_MS 500
// clock rate in kHz (40 MHz)
`define PTR_CLK_KHZ 40000
// interval in cycles: ms * kHz
`define PTR_INTERVAL_CYC (`PTR_INTERVAL_MS * `PTR_CLK_KHZ)
// code-word load time, longest figure in ns
`define PTR_LOAD_NS 100
// automatic exit arming time in ns
`define PTR_ARM_NS 100
// clock period in ns
`define PTR_CLK_NS 25
// least times round up
`define PTR_LOAD_CYC ((`PTR_LOAD_NS + `PTR_CLK_NS - 1) / `PTR_CLK_NS)
`define PTR_ARM_CYC ((`PTR_ARM_NS + `PTR_CLK_NS - 1) / `PTR_CLK_NS)
// self-refresh entry, memory clocks
`define PTR_SR_ENTRY_CYC 25
// dll relock wait, memory clocks
`define PTR_RELOCK_CYC 1000
// ----------------------------------------
// code word
// ----------------------------------------
`define PTR_CODE_W 8
`define PTR_CODE_RST 8'h00
`endif

// >>> core/ptr_timer.v
`default_nettype none
// ----------------------------------------
// down counter with done pulse
// ----------------------------------------
module ptr_timer #(
	parameter W = 32
) (
	// clock and reset
	input wire clock_i,
	input wire rst_i,
	// control
	input wire load_i,
	input wire [W-1:0] value_i,
	// status
	output reg done_o
);
	reg [W-1:0] cnt_q; // remaining cycles
	reg run_q; // counting
	// count down from load, pulse on reaching one
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= {W{1'b0}};
			run_q <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i) begin
				// reload wins over a running count
				cnt_q <= value_i;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					run_q <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/ptr_chk_assertions.sv
`default_nettype none
module ptr_chk (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// inputs
	input wire logic enable_i,
	input wire logic qualified_i,
	input wire logic cal_done_i,
	input wire logic clocks_stopped_i,
	input wire logic user_req_i,
	// outputs
	input wire logic cal_start_o,
	input wire logic sr_enter_o,
	input wire logic sr_exit_o,
	input wire logic zqcs_o,
	input wire logic user_ready_o,
	input wire logic busy_o,
	input wire logic [7:0] buf_code_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// feature on only when both straps hold
	wire on = enable_i & qualified_i;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	chk_exit_with_zq: assert property (sr_exit_o |-> zqcs_o)
		else $error("exit without zq");
	chk_exit_on_req: assert property (sr_exit_o |-> $past(user_req_i))
		else $error("exit without request");
	chk_hold_sr: assert property (sr_enter_o && !user_req_i && !$past(user_req_i) |=> sr_enter_o)
		else $error("self-refresh left early");
	chk_quiet_sr: assert property (sr_enter_o |-> !user_ready_o)
		else $error("traffic in self-refresh");
	chk_code_idle: assert property (!$stable(buf_code_o) |-> !user_ready_o)
		else $error("code changed under traffic");
	chk_load_fast: assert property ($rose(clocks_stopped_i) && sr_enter_o |-> ##[1:10] !$stable(buf_code_o))
		else $error("code not loaded");
	chk_relock_gap: assert property (sr_exit_o |=> !user_ready_o [*8])
		else $error("traffic before relock");
	chk_relock_end: assert property (sr_exit_o |-> ##[1:20] user_ready_o)
		else $error("traffic never resumed");
	chk_no_restart: assert property (cal_done_i |=> !cal_start_o [*8])
		else $error("calibration restarted early");
	chk_off_idle: assert property (!busy_o && !on && !$past(on) && !$past(on, 2) |-> !cal_start_o)
		else $error("calibration while off");
endmodule
bind ptr_seq ptr_chk ptr_chk_i (.clock_i, .rst_i, .enable_i, .qualified_i, .cal_done_i, .clocks_stopped_i,
	.user_req_i, .cal_start_o, .sr_enter_o, .sr_exit_o, .zqcs_o, .user_ready_o, .busy_o, .buf_code_o);
`default_nettype wire

// >>> verif/ptr_partner.sv
`default_nettype none
// resistor calibration engine and controller stand-in
module ptr_partner (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// requests
	input wire logic start_i,
	input wire logic enter_i,
	input wire logic exit_i,
	// answers
	output logic done_o,
	output logic [7:0] code_o,
	output logic in_sr_o,
	output logic stop_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cal_n;
	logic [4:0] sr_n;
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cal_n <= 3'h0;
			sr_n <= 5'h00;
			done_o <= 1'b0;
			code_o <= 8'h10;
			in_sr_o <= 1'b0;
			stop_o <= 1'b0;
		end else begin
			done_o <= cal_n == 3'h1;
			cal_n <= start_i ? 3'h6 : (cal_n != 3'h0 ? cal_n - 3'h1 : cal_n);
			// fresh code each pass, so loads show
			if (cal_n == 3'h1)
				code_o <= code_o + 8'h01;
			if (!enter_i || exit_i)
				sr_n <= 5'h00;
			else if (sr_n != 5'h19)
				sr_n <= sr_n + 5'h01;
			in_sr_o <= enter_i && !exit_i && sr_n == 5'h19;
			stop_o <= in_sr_o && enter_i && !exit_i;
		end
	end
endmodule
`default_nettype wire

// >>> verif/test_periodic_termination_recal.sv
`default_nettype none
module test_periodic_termination_recal;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic enable_i = 1'b0;
	logic qualified_i = 1'b0;
	logic user_req_i = 1'b0;
	logic cal_start_o, cal_done_i, sr_enter_o, sr_entered_i, clocks_stopped_i, sr_exit_o, zqcs_o, user_ready_o, busy_o;
	logic [7:0] cal_code_i, buf_code_o, code;
	int err_count = 0;
	int checked = 0;
	int n, k;
	localparam int DONE = 0, ENTER = 1, STOP = 2, EXIT = 3, READY = 4, START = 5;
	// events the bench waits on
	wire [5:0] ev = {cal_start_o, user_ready_o, sr_exit_o, clocks_stopped_i, sr_enter_o, cal_done_i};
	always #12.5 clock_i = ~clock_i;
	// short interval and relock keep the run brief
	// single interface with its own resistor, so enable may be set
	ptr_seq #(.INTERVAL_CYC(50), .RELOCK_CYC(10)) ptr_seq_i (.clock_i, .rst_i, .enable_i, .qualified_i,
		.cal_start_o, .cal_done_i, .cal_code_i, .sr_enter_o, .sr_entered_i, .clocks_stopped_i,
		.sr_exit_o, .zqcs_o, .user_req_i, .user_ready_o, .buf_code_o, .busy_o);
	ptr_partner ptr_partner_i (.clock_i, .rst_i, .start_i(cal_start_o), .enter_i(sr_enter_o),
		.exit_i(sr_exit_o), .done_o(cal_done_i), .code_o(cal_code_i), .in_sr_o(sr_entered_i),
		.stop_o(clocks_stopped_i));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clock_i);
		#1;
	endtask
	// bounded wait; n ends as cycles spent
	task automatic wait_for(input int idx, input int lim);
		n = 0;
		while (ev[idx] !== 1'b1) begin
			tick(1);
			n++;
			if (n > lim) begin
				err_count++;
				$display("MISMATCH wait %0d expected 1 seen timeout", idx);
				finish_test();
			end
		end
	endtask
	task automatic t_config(input logic en, input logic q);
		@(posedge clock_i);
		rst_i <= 1'b1;
		enable_i <= en;
		qualified_i <= q;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		tick(1);
		check("config start", cal_start_o, 1'b1);
		wait_for(DONE, 20);
		code = cal_code_i;
		tick(2);
		check("config code", buf_code_o, code);
		check("config gated", user_ready_o, 1'b0);
		tick(1);
		check("config ready", user_ready_o, 1'b1);
		check("config idle", busy_o, 1'b0);
	endtask
	task automatic t_periodic;
		t_config(1'b1, 1'b1);
		wait_for(DONE, 80);
		code = cal_code_i;
		check("ready measuring", user_ready_o, 1'b1);
		wait_for(ENTER, 4);
		check("ready in sr", user_ready_o, 1'b0);
		wait_for(STOP, 40);
		tick(12);
		check("new code", buf_code_o, code);
		wait_for(START, 80);
		check("sr held", sr_enter_o, 1'b1);
		check("armed", busy_o, 1'b0);
		@(posedge clock_i);
		user_req_i <= 1'b1;
		wait_for(EXIT, 4);
		check("zq", zqcs_o, 1'b1);
		check("entry dropped", sr_enter_o, 1'b0);
		wait_for(READY, 20);
		check("relock", n >= 10, 1'b1);
		@(posedge clock_i);
		user_req_i <= 1'b0;
		$display("test periodic done");
	endtask
	task automatic t_off(input logic en, input logic q);
		t_config(en, q);
		k = 0;
		repeat (150) begin
			tick(1);
			k += (cal_start_o !== 1'b0);
		end
		check("starts", k[7:0], 8'h00);
		check("no sr", sr_enter_o, 1'b0);
		$display("test off done");
	endtask
	initial begin
		t_periodic();
		t_off(1'b0, 1'b1);
		t_off(1'b1, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
